// ===== src/srcc_pkg.sv
package srcc_pkg;

    // Register bus shape.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFS_AON_CTRL  = 8'h00;
    localparam logic [7:0] OFS_PWR_CTRL  = 8'h04;
    localparam logic [7:0] OFS_CONV_CTRL = 8'h08;
    localparam logic [7:0] OFS_LEVEL     = 8'h0c;
    localparam logic [7:0] OFS_STATUS    = 8'h10;

    // always_on_power_control fields.
    localparam int AON_CLAMP_BIT  = 0;
    localparam int AON_BRIDGE_LSB = 1;
    localparam int AON_PORMSK_BIT = 3;

    // Power control fields.
    localparam int PWR_LOWREG_LSB = 0;
    localparam int PWR_CORERET_BIT = 2;
    localparam int PWR_CMPON_BIT  = 3;
    localparam int PWR_HARDCON_BIT = 4;
    localparam int PWR_PORDIS_BIT = 5;

    // converter_control and level fields.
    localparam int CONV_ON_BIT    = 0;
    localparam int LEVEL_LSB      = 0;

    // Status fields.
    localparam int ST_BOOST_BIT   = 0;
    localparam int ST_CLAMP_BIT   = 1;
    localparam int ST_CONV_BIT    = 2;
    localparam int ST_RESSW_BIT   = 3;
    localparam int ST_POR_BIT     = 4;
    localparam int ST_PORVAL_BIT  = 5;
    localparam int ST_EVENT_BIT   = 6;

    // Rail bridge modes.
    localparam logic [1:0] BRIDGE_DIODE = 2'h0;
    localparam logic [1:0] BRIDGE_FORCE = 2'h1;
    localparam logic [1:0] BRIDGE_SW    = 2'h2;
    localparam logic [1:0] BRIDGE_HW    = 2'h3;

    // Low regulator modes.
    localparam logic [1:0] LOWREG_OFF    = 2'h1;
    localparam logic [1:0] LOWREG_RETAIN = 2'h3;

    // Converter output levels: 1.8 V, 2.5 V, 3.0 V.
    localparam logic [1:0] LEVEL_1V8 = 2'h0;
    localparam logic [1:0] LEVEL_2V5 = 2'h1;
    localparam logic [1:0] LEVEL_3V0 = 2'h2;

    // Reset values.
    localparam logic [1:0] RST_LOWREG = LOWREG_RETAIN;
    localparam logic [1:0] RST_BRIDGE = BRIDGE_DIODE;
    localparam logic [1:0] RST_LEVEL  = LEVEL_1V8;

    // Synchroniser fill time before the boot setup is sampled.
    localparam logic [1:0] BOOT_FILL  = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic              wrStb;
        logic              rdStb;
    } srcc_bus_type;

    typedef struct packed {
        logic [1:0]        shortSync;
        logic [1:0]        lowOnlySync;
        logic [1:0]        aboveSync;
        logic [1:0]        nearSync;
        logic [1:0]        sysOnSync;
        logic [1:0]        sleepSync;
        logic [1:0]        porSync;
        logic              cfgTaken;
        logic [1:0]        bootCnt;
        logic              boostMode;
        logic              clampAutoOff;
        logic [1:0]        bridgeMode;
        logic              porMask;
        logic [1:0]        lowRegMode;
        logic              coreRet;
        logic              cmpOn;
        logic              hardConnect;
        logic              porDisable;
        logic              convOn;
        logic [1:0]        level;
        logic              hwBridged;
        logic              bridgeEvent;
        logic              clampFromHigh;
        logic              converterRun;
        logic              resSwitch;
        logic              porResetReq;
        logic              porStatus;
        logic              porValid;
        logic [DATA_W-1:0] rdData;
    } srcc_state_type;

endpackage

// ===== src/srcc_supply_rail.sv
// Function
// - Clamp follows the higher battery rail by default.
// - Override bit forces clamp onto high rail.
// - Retention fields drive regulator and core retention.
// - Step-down converter runs at level zero when enabled.
// - Converter stops with system domain, then restarts.
// - Reset leaves bridge in diode-only mode.
// - Bridge mode two closes switch during sleep while core retention is on.
// - Bridge mode three closes on comparator match.
// - Level field picks 1.8, 2.5 or 3.0 V.
// - Masked detector keeps status, raises no reset.
// - Disabled detector gives no reset, no status.
// - Shorted rails classify as step-up setup.
// - Setup decided once at cold boot, then held.
// - Converter enable left set restarts on wake.
`timescale 1ns/1ps
module srcc_supply_rail (
    // Clock and reset.
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    // Register port.
    input  wire srcc_pkg::srcc_bus_type     bus,
    output logic [srcc_pkg::DATA_W-1:0]     rdData,
    // Rail sense inputs from the analog side.
    input  wire logic                       railsShorted,
    input  wire logic                       lowRailOnly,
    input  wire logic                       highAboveLow,
    input  wire logic                       highNearLow,
    input  wire logic                       porHighLow,
    // Power manager state.
    input  wire logic                       sysDomainOn,
    input  wire logic                       sleepActive,
    // Supply controls.
    output logic                            clampFromHigh,
    output logic [1:0]                      lowRegulatorMode,
    output logic                            coreRegulatorRetentionOn,
    output logic                            converterRun,
    output logic [1:0]                      converterOutputLevel,
    output logic                            resistiveRailSwitch,
    output logic                            railHardConnect,
    output logic                            highRailComparatorOn,
    output logic                            boostMode,
    // High-rail reset detector.
    output logic                            porHighResetReq,
    output logic                            porHighStatus,
    output logic                            porHighStatusValid
);

    logic [1:0]               rstPipe_ff;
    logic                     rstSync_n;
    srcc_pkg::srcc_state_type q_ff;
    srcc_pkg::srcc_state_type nxt_q;
    logic                     wrHit;
    logic                     hwCloseNow;

    // Reset release goes through two flops so every state flop leaves reset on the same edge.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstPipe_ff <= 2'h0;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_ff[1];

    assign wrHit      = bus.wrStb;
    assign hwCloseNow = q_ff.cmpOn && q_ff.nearSync[1];

    always_comb begin
        nxt_q = q_ff;

        // Pin synchronisers: the first stage feeds only the second.
        nxt_q.shortSync   = {q_ff.shortSync[0], railsShorted};
        nxt_q.lowOnlySync = {q_ff.lowOnlySync[0], lowRailOnly};
        nxt_q.aboveSync   = {q_ff.aboveSync[0], highAboveLow};
        nxt_q.nearSync    = {q_ff.nearSync[0], highNearLow};
        nxt_q.sysOnSync   = {q_ff.sysOnSync[0], sysDomainOn};
        nxt_q.sleepSync   = {q_ff.sleepSync[0], sleepActive};
        nxt_q.porSync     = {q_ff.porSync[0], porHighLow};

        // Cold boot decision.
        // The setup is sampled once, after the synchronisers have filled, and never again.
        // Sampling any earlier would read a cleared synchroniser and always pick step-down.
        if (q_ff.bootCnt != srcc_pkg::BOOT_FILL) begin
            nxt_q.bootCnt = q_ff.bootCnt + 2'h1;
        end else if (!q_ff.cfgTaken) begin
            nxt_q.cfgTaken = 1'b1;
            nxt_q.boostMode = q_ff.shortSync[1] || q_ff.lowOnlySync[1];
        end

        if (wrHit) begin
            case (bus.addr)
                srcc_pkg::OFS_AON_CTRL: begin
                    nxt_q.clampAutoOff = bus.wrData[srcc_pkg::AON_CLAMP_BIT];
                    nxt_q.bridgeMode   = bus.wrData[srcc_pkg::AON_BRIDGE_LSB +: 2];
                    nxt_q.porMask      = bus.wrData[srcc_pkg::AON_PORMSK_BIT];
                end
                srcc_pkg::OFS_PWR_CTRL: begin
                    nxt_q.lowRegMode  = bus.wrData[srcc_pkg::PWR_LOWREG_LSB +: 2];
                    nxt_q.coreRet     = bus.wrData[srcc_pkg::PWR_CORERET_BIT];
                    nxt_q.cmpOn       = bus.wrData[srcc_pkg::PWR_CMPON_BIT];
                    nxt_q.hardConnect = bus.wrData[srcc_pkg::PWR_HARDCON_BIT];
                    nxt_q.porDisable  = bus.wrData[srcc_pkg::PWR_PORDIS_BIT];
                end
                srcc_pkg::OFS_CONV_CTRL: begin
                    nxt_q.convOn = bus.wrData[srcc_pkg::CONV_ON_BIT];
                end
                srcc_pkg::OFS_LEVEL: begin
                    nxt_q.level = bus.wrData[srcc_pkg::LEVEL_LSB +: 2];
                end
                srcc_pkg::OFS_STATUS: begin
                    if (bus.wrData[srcc_pkg::ST_EVENT_BIT]) begin
                        nxt_q.bridgeEvent = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        nxt_q.clampFromHigh = q_ff.clampAutoOff || q_ff.aboveSync[1];

        // Enable survives sleep.
        // The enable is never cleared by the domain going down, so a set bit restarts on wake.
        if (q_ff.boostMode) begin
            nxt_q.converterRun = q_ff.convOn && q_ff.sysOnSync[1];
        end else begin
            nxt_q.converterRun = q_ff.convOn && q_ff.sysOnSync[1] && q_ff.level == srcc_pkg::LEVEL_1V8;
        end

        // Hardware bridge latch.
        // Once closed the bridge stays closed until software leaves mode three, so a noisy
        // comparator cannot chatter the switch.
        if (q_ff.bridgeMode != srcc_pkg::BRIDGE_HW) begin
            nxt_q.hwBridged = 1'b0;
        end else if (hwCloseNow) begin
            nxt_q.hwBridged = 1'b1;
        end
        // Hardware event wins over a clear in the same cycle.
        if (q_ff.bridgeMode == srcc_pkg::BRIDGE_HW && hwCloseNow && !q_ff.hwBridged) begin
            nxt_q.bridgeEvent = 1'b1;
        end

        case (q_ff.bridgeMode)
            srcc_pkg::BRIDGE_FORCE: begin
                nxt_q.resSwitch = 1'b1;
            end
            srcc_pkg::BRIDGE_SW: begin
                nxt_q.resSwitch = q_ff.sleepSync[1] && q_ff.coreRet;
            end
            srcc_pkg::BRIDGE_HW: begin
                nxt_q.resSwitch = q_ff.hwBridged || hwCloseNow;
            end
            default: begin
                nxt_q.resSwitch = 1'b0;
            end
        endcase

        nxt_q.porValid    = !q_ff.porDisable;
        nxt_q.porStatus   = !q_ff.porDisable && q_ff.porSync[1];
        nxt_q.porResetReq = !q_ff.porDisable && !q_ff.porMask && q_ff.porSync[1];

        // Read data stands only in the cycle after the strobe.
        nxt_q.rdData = '0;
        if (bus.rdStb) begin
            case (bus.addr)
                srcc_pkg::OFS_AON_CTRL: begin
                    nxt_q.rdData[srcc_pkg::AON_CLAMP_BIT]       = q_ff.clampAutoOff;
                    nxt_q.rdData[srcc_pkg::AON_BRIDGE_LSB +: 2] = q_ff.bridgeMode;
                    nxt_q.rdData[srcc_pkg::AON_PORMSK_BIT]      = q_ff.porMask;
                end
                srcc_pkg::OFS_PWR_CTRL: begin
                    nxt_q.rdData[srcc_pkg::PWR_LOWREG_LSB +: 2] = q_ff.lowRegMode;
                    nxt_q.rdData[srcc_pkg::PWR_CORERET_BIT]     = q_ff.coreRet;
                    nxt_q.rdData[srcc_pkg::PWR_CMPON_BIT]       = q_ff.cmpOn;
                    nxt_q.rdData[srcc_pkg::PWR_HARDCON_BIT]     = q_ff.hardConnect;
                    nxt_q.rdData[srcc_pkg::PWR_PORDIS_BIT]      = q_ff.porDisable;
                end
                srcc_pkg::OFS_CONV_CTRL: begin
                    nxt_q.rdData[srcc_pkg::CONV_ON_BIT] = q_ff.convOn;
                end
                srcc_pkg::OFS_LEVEL: begin
                    nxt_q.rdData[srcc_pkg::LEVEL_LSB +: 2] = q_ff.level;
                end
                srcc_pkg::OFS_STATUS: begin
                    nxt_q.rdData[srcc_pkg::ST_BOOST_BIT]  = q_ff.boostMode;
                    nxt_q.rdData[srcc_pkg::ST_CLAMP_BIT]  = q_ff.clampFromHigh;
                    nxt_q.rdData[srcc_pkg::ST_CONV_BIT]   = q_ff.converterRun;
                    nxt_q.rdData[srcc_pkg::ST_RESSW_BIT]  = q_ff.resSwitch;
                    nxt_q.rdData[srcc_pkg::ST_POR_BIT]    = q_ff.porStatus;
                    nxt_q.rdData[srcc_pkg::ST_PORVAL_BIT] = q_ff.porValid;
                    nxt_q.rdData[srcc_pkg::ST_EVENT_BIT]  = q_ff.bridgeEvent;
                end
                default: begin
                    nxt_q.rdData = '0;
                end
            endcase
        end
    end

    // Always-on state.
    // Only the reset pin clears these, so sleep transitions leave every register field untouched.
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            q_ff            <= '0;
            q_ff.lowRegMode <= srcc_pkg::RST_LOWREG;
            q_ff.bridgeMode <= srcc_pkg::RST_BRIDGE;
            q_ff.level      <= srcc_pkg::RST_LEVEL;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign lowRegulatorMode         = q_ff.lowRegMode;
    assign coreRegulatorRetentionOn = q_ff.coreRet;
    assign converterOutputLevel     = q_ff.level;
    assign railHardConnect          = q_ff.hardConnect;
    assign highRailComparatorOn     = q_ff.cmpOn;
    assign boostMode                = q_ff.boostMode;
    assign clampFromHigh            = q_ff.clampFromHigh;
    assign converterRun             = q_ff.converterRun;
    assign resistiveRailSwitch      = q_ff.resSwitch;
    assign porHighResetReq          = q_ff.porResetReq;
    assign porHighStatus            = q_ff.porStatus;
    assign porHighStatusValid       = q_ff.porValid;
    assign rdData                   = q_ff.rdData;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstSync_n);

    a_clamp_auto_low: assert property (
        !q_ff.clampAutoOff && !q_ff.aboveSync[1] |=> !clampFromHigh)
        else $error("Clamp left on high rail while low rail is higher.");

    a_clamp_override: assert property (
        q_ff.clampAutoOff [*2] |=> clampFromHigh)
        else $error("Clamp override did not select the high rail.");

    a_retain_write: assert property (
        bus.wrStb && bus.addr == srcc_pkg::OFS_PWR_CTRL
        |=> lowRegulatorMode == $past(bus.wrData[1:0]) && coreRegulatorRetentionOn == $past(bus.wrData[2]))
        else $error("Retention fields did not take the written value.");

    a_conv_buck_run: assert property (
        !q_ff.boostMode && q_ff.convOn && q_ff.level == srcc_pkg::LEVEL_1V8 && q_ff.sysOnSync[1]
        |=> converterRun)
        else $error("Step-down converter not running when enabled.");

    a_conv_domain_off: assert property (
        !q_ff.sysOnSync[1] |=> !converterRun)
        else $error("Converter running with system domain down.");

    a_conv_wake_restart: assert property (
        q_ff.convOn && q_ff.boostMode && $rose(q_ff.sysOnSync[1]) |=> converterRun)
        else $error("Converter did not restart on wake.");

    a_bridge_diode: assert property (
        q_ff.bridgeMode == srcc_pkg::BRIDGE_DIODE |=> !resistiveRailSwitch)
        else $error("Resistive switch closed in diode-only mode.");

    a_bridge_sw_sleep: assert property (
        q_ff.bridgeMode == srcc_pkg::BRIDGE_SW && q_ff.sleepSync[1] && q_ff.coreRet |=> resistiveRailSwitch)
        else $error("Software bridge open during sleep.");

    a_bridge_hw_close: assert property (
        q_ff.bridgeMode == srcc_pkg::BRIDGE_HW && q_ff.cmpOn && q_ff.nearSync[1]
        |=> resistiveRailSwitch ##1 (resistiveRailSwitch || q_ff.bridgeMode != srcc_pkg::BRIDGE_HW))
        else $error("Hardware bridge did not close and hold.");

    a_level_hold: assert property (
        !(bus.wrStb && bus.addr == srcc_pkg::OFS_LEVEL) |=> $stable(converterOutputLevel))
        else $error("Converter level changed without a write.");

    a_por_masked: assert property (
        q_ff.porMask && !q_ff.porDisable && q_ff.porSync[1] |=> !porHighResetReq && porHighStatus)
        else $error("Masked detector wrong reset or status.");

    a_por_disabled: assert property (
        q_ff.porDisable |=> !porHighResetReq && !porHighStatus && !porHighStatusValid)
        else $error("Disabled detector still reports.");

    a_cfg_shorted: assert property (
        !q_ff.cfgTaken && q_ff.bootCnt == srcc_pkg::BOOT_FILL && q_ff.shortSync[1] |=> boostMode)
        else $error("Shorted rails not classified as step-up.");

    a_cfg_held: assert property (
        q_ff.cfgTaken |=> q_ff.cfgTaken && $stable(boostMode))
        else $error("Setup decision changed after cold boot.");

    a_cfg_sample: assert property (
        !q_ff.cfgTaken && q_ff.bootCnt == srcc_pkg::BOOT_FILL
        |=> boostMode == ($past(q_ff.shortSync[1]) || $past(q_ff.lowOnlySync[1])))
        else $error("Boot setup not taken from the synchronised pins.");

    a_conv_boost_run: assert property (
        q_ff.boostMode && q_ff.convOn && q_ff.sysOnSync[1] |=> converterRun)
        else $error("Step-up converter not running at its selected level.");

    a_bridge_event_set: assert property (
        q_ff.bridgeMode == srcc_pkg::BRIDGE_HW && hwCloseNow && !q_ff.hwBridged |=> q_ff.bridgeEvent)
        else $error("Hardware bridge closure not recorded.");

    a_bridge_hw_open: assert property (
        q_ff.bridgeMode != srcc_pkg::BRIDGE_HW |=> !q_ff.hwBridged)
        else $error("Hardware bridge latch kept outside mode three.");

    a_por_active: assert property (
        !q_ff.porDisable && !q_ff.porMask && q_ff.porSync[1] |=> porHighResetReq && porHighStatus)
        else $error("Unmasked detector raised no reset.");

    a_read_idle: assert property (
        !bus.rdStb |=> rdData == '0)
        else $error("Read data present without a read strobe.");

    a_read_level: assert property (
        bus.rdStb && bus.addr == srcc_pkg::OFS_LEVEL
        |=> rdData[srcc_pkg::LEVEL_LSB +: 2] == $past(converterOutputLevel))
        else $error("Level field read back wrong.");

    c_hw_bridge: cover property (q_ff.bridgeMode == srcc_pkg::BRIDGE_HW ##1 $rose(resistiveRailSwitch));
    c_conv_run: cover property ($rose(converterRun));
    c_por_masked: cover property (porHighStatus && !porHighResetReq);
    c_boost_cfg: cover property ($rose(boostMode));
    c_bridge_sw: cover property (q_ff.bridgeMode == srcc_pkg::BRIDGE_SW && $rose(resistiveRailSwitch));

endmodule

// ===== testbench/tb_supply_rail_config_control.sv
`timescale 1ns/1ps
module tb_supply_rail_config_control;
    logic                        core_clk;
    logic                        nrst;
    srcc_pkg::srcc_bus_type      bus;
    logic [srcc_pkg::DATA_W-1:0] rdData;
    logic [31:0]                 rd;
    logic                        railsShorted, lowRailOnly, highAboveLow, highNearLow, porHighLow;
    logic                        sysDomainOn, sleepActive;
    logic                        clampFromHigh, coreRegulatorRetentionOn, converterRun, resistiveRailSwitch;
    logic                        railHardConnect, highRailComparatorOn, boostMode;
    logic                        porHighResetReq, porHighStatus, porHighStatusValid;
    logic [1:0]                  lowRegulatorMode, converterOutputLevel;
    logic [1:0]                  levels [3] = '{srcc_pkg::LEVEL_1V8, srcc_pkg::LEVEL_2V5, srcc_pkg::LEVEL_3V0};
    int                          mismatches;
    int                          samplesChecked;
    int                          cycles;

    srcc_supply_rail srcc_supply_rail_inst (
        .core_clk, .nrst, .bus, .rdData,
        .railsShorted, .lowRailOnly, .highAboveLow, .highNearLow, .porHighLow,
        .sysDomainOn, .sleepActive,
        .clampFromHigh, .lowRegulatorMode, .coreRegulatorRetentionOn, .converterRun,
        .converterOutputLevel, .resistiveRailSwitch, .railHardConnect, .highRailComparatorOn,
        .boostMode, .porHighResetReq, .porHighStatus, .porHighStatusValid
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic printVerdict;
        $display("comparisons %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hang would otherwise never reach the closing report.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            printVerdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus.addr   <= a;
        bus.wrData <= d;
        bus.wrStb  <= 1'b1;
        @(posedge core_clk);
        bus.wrStb  <= 1'b0;
    endtask

    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus.addr  <= a;
        bus.rdStb <= 1'b1;
        @(posedge core_clk);
        bus.rdStb <= 1'b0;
        #1;
        d = rdData;
    endtask

    task automatic checkReg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        regRead(a, d);
        check(d, exp);
    endtask

    // Rail sense inputs pass two sync flops and an output flop, so four edges cover them.
    task automatic settle;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    task automatic resetPulse;
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
    endtask

    initial begin
        bus = '0;
        nrst = 1'b0;
        {railsShorted, lowRailOnly, highAboveLow, highNearLow, porHighLow, sleepActive} = '0;
        sysDomainOn = 1'b1;
        mismatches = 0;
        samplesChecked = 0;
        cycles = 0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        chk1(resistiveRailSwitch, 1'b0);
        checkReg(srcc_pkg::OFS_AON_CTRL, 32'h0);
        checkReg(srcc_pkg::OFS_PWR_CTRL, 32'(srcc_pkg::RST_LOWREG));
        checkReg(srcc_pkg::OFS_LEVEL, 32'(srcc_pkg::RST_LEVEL));
        checkReg(8'h20, 32'h0);
        chk1(boostMode, 1'b0);
        $display("test reset values done");

        @(posedge core_clk) highAboveLow <= 1'b1;
        settle();
        chk1(clampFromHigh, 1'b1);
        @(posedge core_clk) highAboveLow <= 1'b0;
        settle();
        chk1(clampFromHigh, 1'b0);
        regWrite(srcc_pkg::OFS_AON_CTRL, 32'h1 << srcc_pkg::AON_CLAMP_BIT);
        settle();
        chk1(clampFromHigh, 1'b1);
        checkReg(srcc_pkg::OFS_STATUS, (32'h1 << srcc_pkg::ST_CLAMP_BIT) | (32'h1 << srcc_pkg::ST_PORVAL_BIT));
        regWrite(srcc_pkg::OFS_AON_CTRL, 32'h0);
        $display("test clamp supply done");

        regWrite(srcc_pkg::OFS_PWR_CTRL, 32'h3 | (32'h1 << srcc_pkg::PWR_CORERET_BIT));
        settle();
        check(32'(lowRegulatorMode), 32'(srcc_pkg::LOWREG_RETAIN));
        chk1(coreRegulatorRetentionOn, 1'b1);
        regWrite(srcc_pkg::OFS_PWR_CTRL, 32'(srcc_pkg::LOWREG_OFF));
        settle();
        check(32'(lowRegulatorMode), 32'h1);
        $display("test regulator modes done");

        regWrite(srcc_pkg::OFS_CONV_CTRL, 32'h1);
        settle();
        chk1(converterRun, 1'b1);
        regWrite(srcc_pkg::OFS_LEVEL, 32'(srcc_pkg::LEVEL_2V5));
        settle();
        chk1(converterRun, 1'b0);
        regWrite(srcc_pkg::OFS_LEVEL, 32'h0);
        @(posedge core_clk) sysDomainOn <= 1'b0;
        settle();
        chk1(converterRun, 1'b0);
        checkReg(srcc_pkg::OFS_CONV_CTRL, 32'h1);
        @(posedge core_clk) sysDomainOn <= 1'b1;
        settle();
        chk1(converterRun, 1'b1);
        regWrite(srcc_pkg::OFS_CONV_CTRL, 32'h0);
        @(posedge core_clk) sysDomainOn <= 1'b0;
        settle();
        @(posedge core_clk) sysDomainOn <= 1'b1;
        settle();
        chk1(converterRun, 1'b0);
        regWrite(srcc_pkg::OFS_CONV_CTRL, 32'h1);
        settle();
        chk1(converterRun, 1'b1);
        for (int i = 0; i < 3; i++) begin
            regWrite(srcc_pkg::OFS_LEVEL, 32'(levels[i]));
            settle();
            check(32'(converterOutputLevel), 32'(levels[i]));
            checkReg(srcc_pkg::OFS_LEVEL, 32'(levels[i]));
        end
        $display("test converter done");

        regWrite(srcc_pkg::OFS_PWR_CTRL, 32'h1 << srcc_pkg::PWR_CORERET_BIT);
        regWrite(srcc_pkg::OFS_AON_CTRL, 32'(srcc_pkg::BRIDGE_SW) << srcc_pkg::AON_BRIDGE_LSB);
        settle();
        chk1(resistiveRailSwitch, 1'b0);
        @(posedge core_clk) sleepActive <= 1'b1;
        settle();
        chk1(resistiveRailSwitch, 1'b1);
        checkReg(srcc_pkg::OFS_AON_CTRL, 32'(srcc_pkg::BRIDGE_SW) << srcc_pkg::AON_BRIDGE_LSB);
        @(posedge core_clk) sleepActive <= 1'b0;
        settle();
        chk1(resistiveRailSwitch, 1'b0);
        regWrite(srcc_pkg::OFS_AON_CTRL, 32'(srcc_pkg::BRIDGE_FORCE) << srcc_pkg::AON_BRIDGE_LSB);
        settle();
        chk1(resistiveRailSwitch, 1'b1);
        $display("test bridge software modes done");

        regWrite(srcc_pkg::OFS_PWR_CTRL, (32'h1 << srcc_pkg::PWR_CORERET_BIT) | (32'h1 << srcc_pkg::PWR_CMPON_BIT));
        regWrite(srcc_pkg::OFS_AON_CTRL, 32'(srcc_pkg::BRIDGE_HW) << srcc_pkg::AON_BRIDGE_LSB);
        settle();
        chk1(highRailComparatorOn, 1'b1);
        chk1(resistiveRailSwitch, 1'b0);
        @(posedge core_clk) highNearLow <= 1'b1;
        settle();
        chk1(resistiveRailSwitch, 1'b1);
        regRead(srcc_pkg::OFS_STATUS, rd);
        check(rd & 32'h48, 32'h48);
        @(posedge core_clk) highNearLow <= 1'b0;
        settle();
        chk1(resistiveRailSwitch, 1'b1);
        regWrite(srcc_pkg::OFS_STATUS, 32'h1 << srcc_pkg::ST_EVENT_BIT);
        regRead(srcc_pkg::OFS_STATUS, rd);
        check(rd & 32'h40, 32'h0);
        regWrite(srcc_pkg::OFS_AON_CTRL, 32'h0);
        settle();
        chk1(resistiveRailSwitch, 1'b0);
        $display("test bridge hardware mode done");

        @(posedge core_clk) porHighLow <= 1'b1;
        settle();
        chk1(porHighResetReq, 1'b1);
        regWrite(srcc_pkg::OFS_AON_CTRL, 32'h1 << srcc_pkg::AON_PORMSK_BIT);
        settle();
        chk1(porHighResetReq, 1'b0);
        chk1(porHighStatus, 1'b1);
        chk1(porHighStatusValid, 1'b1);
        regWrite(srcc_pkg::OFS_AON_CTRL, 32'h0);
        regWrite(srcc_pkg::OFS_PWR_CTRL, 32'h1 << srcc_pkg::PWR_PORDIS_BIT);
        settle();
        chk1(porHighResetReq, 1'b0);
        chk1(porHighStatus, 1'b0);
        chk1(porHighStatusValid, 1'b0);
        @(posedge core_clk) porHighLow <= 1'b0;
        $display("test high rail detector done");

        railsShorted <= 1'b1;
        resetPulse();
        chk1(boostMode, 1'b1);
        checkReg(srcc_pkg::OFS_AON_CTRL, 32'h0);
        @(posedge core_clk) railsShorted <= 1'b0;
        settle();
        chk1(boostMode, 1'b1);
        regWrite(srcc_pkg::OFS_LEVEL, 32'(srcc_pkg::LEVEL_3V0));
        regWrite(srcc_pkg::OFS_CONV_CTRL, 32'h1);
        settle();
        chk1(converterRun, 1'b1);
        regWrite(srcc_pkg::OFS_AON_CTRL, 32'h1 << srcc_pkg::AON_PORMSK_BIT);
        regWrite(srcc_pkg::OFS_CONV_CTRL, 32'h0);
        regWrite(srcc_pkg::OFS_PWR_CTRL, 32'h1 << srcc_pkg::PWR_HARDCON_BIT);
        settle();
        chk1(converterRun, 1'b0);
        chk1(railHardConnect, 1'b1);
        regWrite(srcc_pkg::OFS_PWR_CTRL, 32'(srcc_pkg::LOWREG_OFF));
        settle();
        check(32'(lowRegulatorMode), 32'h1);
        chk1(converterRun, 1'b0);
        @(posedge core_clk) porHighLow <= 1'b1;
        settle();
        chk1(porHighResetReq, 1'b0);
        chk1(porHighStatus, 1'b1);
        $display("test step-up setup done");
        printVerdict();
    end
endmodule
